//--- design/led_matrix_consts.svh
`ifndef LED_MATRIX_CONSTS_SVH
`define LED_MATRIX_CONSTS_SVH
// Register byte offsets
`define OFS_TIMING      8'h00
`define OFS_COMP        8'h04
`define OFS_DEGHOST     8'h08
`define OFS_PEAK        8'h0c
`define OFS_COLOR       8'h10
`define OFS_RUN         8'h14
`define OFS_DOT_IDX     8'h18
`define OFS_DOT_GAIN    8'h1c
`define OFS_STATUS      8'h20
`define OFS_CURRENT     8'h24
`define OFS_AVG         8'h28
// Timing register fields
`define TIM_PWM_SLOW_BIT  0
`define TIM_BLANK_BIT     1
`define TIM_PHASE_BIT     2
`define TIM_SHIFT_BIT     3
`define TIM_LINES_LSB     4
`define TIM_MODE_LSB      8
// Reset values and line count limits
`define RST_LINES       4'hb
`define RST_PEAK        3'h3
`define RST_COLOR       7'h40
`define RST_DOT         8'h80
`define RST_MODE        2'h1
`define MIN_LINES       4'h6
`define MAX_LINES       4'hb
// Times in ns, clock 20 ns
`define CLK_NS          20
`define T_PWM_FAST_NS   8000
`define T_PWM_SLOW_NS   16000
`define T_BLANK_LONG_NS 1000
`define T_BLANK_SHORT_NS 500
`define T_PHASE_NS      125
`define T_SINK_DLY_NS   20
`define CYC_PWM_FAST    (`T_PWM_FAST_NS / `CLK_NS)
`define CYC_PWM_SLOW    (`T_PWM_SLOW_NS / `CLK_NS)
`define CYC_BLANK_LONG  (`T_BLANK_LONG_NS / `CLK_NS)
`define CYC_BLANK_SHORT (`T_BLANK_SHORT_NS / `CLK_NS)
`define CYC_PHASE       ((`T_PHASE_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_SINK_DLY    ((`T_SINK_DLY_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- design/led_matrix_pkg.sv
package led_matrix_pkg;
  typedef enum logic [1:0] {ph_blank, ph_shift, ph_active} slot_phase_t;
  typedef logic [6:0] gain7_t;
endpackage

//--- design/led_matrix_scan_current_gain.sv
`timescale 1ns/1ps
`include "led_matrix_consts.svh"
module led_matrix_scan_current_gain #(
  parameter int LINES = 11,
  parameter int SINKS = 18
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Matrix drive
  output logic [LINES-1:0]       line_on_o,
  output logic [SINKS-1:0]       sink_on_o,
  output logic                   line_clamp_o,
  output logic [2:0]             sink_precharge_o,
  output logic [2:0]             sink_comp_o [SINKS],
  output logic                   subperiod_start_o
);
  localparam int CW = 11;
  localparam logic [CW-1:0] PWM_F = CW'(`CYC_PWM_FAST);
  localparam logic [CW-1:0] PWM_S = CW'(`CYC_PWM_SLOW);
  localparam logic [CW-1:0] BLK_L = CW'(`CYC_BLANK_LONG);
  localparam logic [CW-1:0] BLK_S = CW'(`CYC_BLANK_SHORT);
  localparam logic [CW-1:0] PHS   = CW'(`CYC_PHASE);
  localparam logic [CW-1:0] SDLY  = CW'(`CYC_SINK_DLY);

  // Peak current in units of 0.5 mA; 111 never reaches here
  function automatic logic [7:0] peak_half_ma(input logic [2:0] c);
    unique case (c)
      3'h0: peak_half_ma = 8'h0f;
      3'h1: peak_half_ma = 8'h19;
      3'h2: peak_half_ma = 8'h32;
      3'h3: peak_half_ma = 8'h4b;
      3'h4: peak_half_ma = 8'h64;
      3'h5: peak_half_ma = 8'h96;
      3'h6: peak_half_ma = 8'hc8;
      default: peak_half_ma = 8'h4b;
    endcase
  endfunction

  function automatic logic [1:0] grp(input int i);
    grp = 2'(i % 3);
  endfunction

  // Configuration registers
  logic [31:0] timing_config_reg_q;
  logic [8:0]  compensation_config_reg_q;
  logic [3:0]  deghost_config_reg_q;
  logic [2:0]  peak_current_code_q;
  led_matrix_pkg::gain7_t color_gain_a_q, color_gain_b_q, color_gain_c_q;
  logic        run_q;
  logic [4:0]  dot_idx_q;
  logic [7:0]  dot_gain_q [SINKS];
  logic [2:0]  peak_applied_q;
  logic [3:0]  deghost_applied_q;

  logic        wr;
  logic        rd;
  logic [1:0]  mode;
  logic [3:0]  lines_cfg;
  logic [3:0]  lines_n;
  logic        deferred;

  // A write lands at the edge where the master sees ack, while the request still stands
  assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  assign rd = cyc_i && stb_i && !ack_o;
  assign mode = timing_config_reg_q[`TIM_MODE_LSB +: 2];
  assign lines_cfg = timing_config_reg_q[`TIM_LINES_LSB +: 4];
  assign deferred = (mode != 2'h1);

  // Write strobe of one register offset
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs, input logic w);
    wr_hit = w && (a == ofs);
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timing_config_reg_q <= 32'h0;
      timing_config_reg_q[`TIM_LINES_LSB +: 4] <= `RST_LINES;
      timing_config_reg_q[`TIM_MODE_LSB +: 2] <= `RST_MODE;
    end
    else if (wr_hit(adr_i, `OFS_TIMING, wr))
    begin
      timing_config_reg_q <= {22'h0, dat_i[9:0]};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      compensation_config_reg_q <= 9'h0;
    end
    else if (wr_hit(adr_i, `OFS_COMP, wr))
    begin
      compensation_config_reg_q <= dat_i[8:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      deghost_config_reg_q <= 4'h0;
    end
    else if (wr_hit(adr_i, `OFS_DEGHOST, wr))
    begin
      deghost_config_reg_q <= dat_i[3:0];
    end
  end

  // Code 111 has no current level, so the old code is kept
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      peak_current_code_q <= `RST_PEAK;
    end
    else if (wr_hit(adr_i, `OFS_PEAK, wr) && dat_i[2:0] != 3'h7)
    begin
      peak_current_code_q <= dat_i[2:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      color_gain_a_q <= `RST_COLOR;
      color_gain_b_q <= `RST_COLOR;
      color_gain_c_q <= `RST_COLOR;
    end
    else if (wr_hit(adr_i, `OFS_COLOR, wr))
    begin
      color_gain_a_q <= dat_i[6:0];
      color_gain_b_q <= dat_i[14:8];
      color_gain_c_q <= dat_i[22:16];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_q <= 1'b0;
    end
    else if (wr_hit(adr_i, `OFS_RUN, wr))
    begin
      run_q <= dat_i[0];
    end
  end

  // An index past the last sink is refused so the gain array is never overrun
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dot_idx_q <= 5'h0;
    end
    else if (wr_hit(adr_i, `OFS_DOT_IDX, wr) && dat_i[4:0] < 5'(SINKS))
    begin
      dot_idx_q <= dat_i[4:0];
    end
  end

  // Per-dot gain storage, indexed
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < SINKS; i++)
        dot_gain_q[i] <= `RST_DOT;
    end
    else if (wr_hit(adr_i, `OFS_DOT_GAIN, wr))
      dot_gain_q[dot_idx_q] <= dat_i[7:0];
  end

  // Applied settings: immediate in mode 1, held while stopped in modes 0/2/3
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      peak_applied_q <= `RST_PEAK;
      deghost_applied_q <= 4'h0;
    end
    else if (!deferred || run_q)
    begin
      peak_applied_q <= peak_current_code_q;
      deghost_applied_q <= deghost_config_reg_q;
    end
  end

  // Line count clamped into the legal range
  assign lines_n = (lines_cfg < `MIN_LINES) ? `MIN_LINES :
                   (lines_cfg > `MAX_LINES) ? `MAX_LINES : lines_cfg;

  // Slot phase lengths
  logic [CW-1:0] pwm_len;
  logic [CW-1:0] blk_len;
  logic [CW-1:0] shf_len;
  assign pwm_len = timing_config_reg_q[`TIM_PWM_SLOW_BIT] ? PWM_S : PWM_F;
  assign blk_len = timing_config_reg_q[`TIM_BLANK_BIT] ? BLK_S : BLK_L;
  assign shf_len = timing_config_reg_q[`TIM_PHASE_BIT] ? CW'(PHS * 2) : '0;

  // Scan sequencer; idles while run is low
  led_matrix_pkg::slot_phase_t phase_q;
  logic [CW-1:0] cnt_q;
  logic [3:0]    line_q;
  logic          last_cyc;
  logic [CW-1:0] phase_len;
  always_comb
  begin
    unique case (phase_q)
      led_matrix_pkg::ph_blank:  phase_len = blk_len;
      led_matrix_pkg::ph_shift:  phase_len = shf_len;
      led_matrix_pkg::ph_active: phase_len = pwm_len;
    endcase
  end
  assign last_cyc = (cnt_q + CW'(1) >= phase_len);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_q)
    begin
      phase_q <= led_matrix_pkg::ph_blank;
      cnt_q <= '0;
      line_q <= 4'h0;
    end
    else if (last_cyc)
    begin
      cnt_q <= '0;
      unique case (phase_q)
        // A zero shift must not cost a cycle of slot time
        led_matrix_pkg::ph_blank:  phase_q <= (shf_len == '0) ? led_matrix_pkg::ph_active :
                                              led_matrix_pkg::ph_shift;
        led_matrix_pkg::ph_shift:  phase_q <= led_matrix_pkg::ph_active;
        led_matrix_pkg::ph_active:
        begin
          phase_q <= led_matrix_pkg::ph_blank;
          line_q <= (line_q + 4'h1 >= lines_n) ? 4'h0 : line_q + 4'h1;
        end
      endcase
    end
    else
      cnt_q <= cnt_q + CW'(1);
  end

  // Matrix outputs, one register per concern
  logic active;
  logic sink_go;
  assign active = run_q && (phase_q == led_matrix_pkg::ph_active);
  assign sink_go = active && (!timing_config_reg_q[`TIM_SHIFT_BIT] || cnt_q >= SDLY);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      line_on_o <= '0;
    end
    else
    begin
      line_on_o <= active ? LINES'(1) << line_q : '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      line_clamp_o <= 1'b0;
    end
    else
    begin
      line_clamp_o <= run_q && !active && deghost_applied_q[3];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sink_precharge_o <= 3'h0;
    end
    else
    begin
      sink_precharge_o <= (run_q && !active) ? deghost_applied_q[2:0] : 3'h0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      subperiod_start_o <= 1'b0;
    end
    else
    begin
      subperiod_start_o <= run_q && line_q == 4'h0 && cnt_q == '0 && phase_q == led_matrix_pkg::ph_blank;
    end
  end

  // Per-sink enable and compensation strength
  for (genvar s = 0; s < SINKS; s++)
  begin : g_sink
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        sink_on_o[s] <= 1'b0;
        sink_comp_o[s] <= 3'h0;
      end
      else
      begin
        sink_on_o[s] <= sink_go && dot_gain_q[s] != 8'h0;
        sink_comp_o[s] <= compensation_config_reg_q[3*grp(s) +: 3];
      end
    end
  end

  // Current of the selected dot in microamps, computed combinationally
  logic [6:0]  cg_sel;
  logic [31:0] i_dot_ua;
  logic [31:0] i_avg_ua;
  always_comb
  begin
    unique case (grp(int'(dot_idx_q)))
      2'h0: cg_sel = color_gain_a_q;
      2'h1: cg_sel = color_gain_b_q;
      default: cg_sel = color_gain_c_q;
    endcase
  end
  // Division is combinational; acceptable as it feeds a read-only register
  assign i_dot_ua = (32'(peak_half_ma(peak_applied_q)) * 32'd500 * 32'(cg_sel) * 32'(dot_gain_q[dot_idx_q]))
                    / 32'd32385;
  assign i_avg_ua = i_dot_ua / 32'(lines_n);

  // Bus answer: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
    end
    else
    begin
      ack_o <= rd;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= 32'h0;
    end
    else
    begin
      if (rd)
      begin
        unique case (adr_i)
          `OFS_TIMING:   dat_o <= timing_config_reg_q;
          `OFS_COMP:     dat_o <= {23'h0, compensation_config_reg_q};
          `OFS_DEGHOST:  dat_o <= {28'h0, deghost_config_reg_q};
          `OFS_PEAK:     dat_o <= {29'h0, peak_current_code_q};
          `OFS_COLOR:    dat_o <= {9'h0, color_gain_c_q, 1'b0, color_gain_b_q, 1'b0, color_gain_a_q};
          `OFS_RUN:      dat_o <= {31'h0, run_q};
          `OFS_DOT_IDX:  dat_o <= {27'h0, dot_idx_q};
          `OFS_DOT_GAIN: dat_o <= {24'h0, dot_gain_q[dot_idx_q]};
          `OFS_STATUS:   dat_o <= {21'h0, peak_applied_q, line_q, 2'h0, phase_q};
          `OFS_CURRENT:  dat_o <= i_dot_ua;
          `OFS_AVG:      dat_o <= i_avg_ua;
          default:       dat_o <= 32'h0;
        endcase
      end
    end
  end
endmodule // led_matrix_scan_current_gain

//--- tb/led_matrix_checker.sv
`timescale 1ns/1ps
module led_matrix_checker #(
  parameter int LINES = 11,
  parameter int SINKS = 18
) (
  // Clock, reset and bus
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic [31:0]      dat_o,
  input wire logic             ack_o,
  // Matrix drive
  input wire logic [LINES-1:0] line_on_o,
  input wire logic [SINKS-1:0] sink_on_o,
  input wire logic [2:0]       sink_comp_o [SINKS],
  input wire logic             subperiod_start_o
);
  logic [LINES-1:0] last_q;
  logic             comp_ok;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Blank gaps show no line, so order is judged against the last lit one
  always_ff @(posedge clk_i)
    if (rst_i)
      last_q <= '0;
    else if (line_on_o != '0)
      last_q <= line_on_o;
  always_comb
  begin
    comp_ok = 1'b1;
    for (int s = 3; s < SINKS; s++)
      if (sink_comp_o[s] != sink_comp_o[s-3])
        comp_ok = 1'b0;
  end
  AST_ONEHOT: assert property ($onehot0(line_on_o)) else $error("two lines on");
  AST_ORDER: assert property (line_on_o != '0 && line_on_o != last_q |->
    line_on_o == 1 || line_on_o == (last_q << 1)) else $error("line order broken");
  AST_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack too long");
  AST_NOACK: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack unasked");
  AST_DAT_HOLD: assert property (!ack_o ##1 !ack_o |-> $stable(dat_o)) else $error("read data moved");
  AST_COMP: assert property (comp_ok) else $error("comp group split");
  AST_SINK_LINE: assert property (sink_on_o != '0 |-> line_on_o != '0) else $error("sink outside line");
  AST_SUB_GAP: assert property (subperiod_start_o |=> !subperiod_start_o [*8]) else $error("sub-period short");
  AST_RST_OUT: assert property ($fell(rst_i) |-> line_on_o == '0 && !ack_o) else $error("busy after reset");
  COV_SUB: cover property (subperiod_start_o);
  COV_ACK: cover property (ack_o);
  COV_TOP: cover property ($rose(line_on_o[LINES-1]));
endmodule // led_matrix_checker
bind led_matrix_scan_current_gain led_matrix_checker #(.LINES(LINES), .SINKS(SINKS)) chk_u (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .line_on_o(line_on_o),
  .sink_on_o(sink_on_o),
  .sink_comp_o(sink_comp_o), .subperiod_start_o(subperiod_start_o));

//--- tb/led_matrix_model.sv
`timescale 1ns/1ps
module led_matrix_model #(
  parameter int LINES = 11
) (
  // Matrix side
  input  wire logic             clk_i,
  input  wire logic             clr_i,
  input  wire logic [LINES-1:0] line_on_i,
  // Observation
  output logic      [3:0]       top_line_o,
  output logic                  clash_o
);
  // Two lit rows short the matrix, so the flag is sticky
  always_ff @(posedge clk_i)
  begin
    if (clr_i)
      clash_o <= 1'b0;
    else if (!$onehot0(line_on_i))
      clash_o <= 1'b1;
    if (clr_i)
      top_line_o <= 4'h0;
    else
      for (int i = 0; i < LINES; i++)
        if (line_on_i[i] && i > top_line_o)
          top_line_o <= 4'(i);
  end
endmodule // led_matrix_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, mclr = 1'b1;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic        ack_o, line_clamp_o, subperiod_start_o, clash;
  logic [10:0] line_on_o;
  logic [17:0] sink_on_o;
  logic [2:0]  sink_precharge_o;
  logic [2:0]  sink_comp_o [18];
  logic [3:0]  top_line;
  int          error_cnt = 0, compares = 0, n, len;
  logic [31:0] ra [10] = '{32'h00, 32'h04, 32'h08, 32'h0c, 32'h10, 32'h14, 32'h1c, 32'h24, 32'h28, 32'h30};
  logic [31:0] rv [10] = '{32'h1b0, 32'h0, 32'h0, 32'h3, 32'h404040, 32'h0, 32'h80, 32'h250d, 32'h35e, 32'h0};
  logic [31:0] pk [7] = '{32'h1d4c, 32'h30d4, 32'h61a8, 32'h927c, 32'hc350, 32'h124f8, 32'h186a0};
  logic [31:0] tc [4] = '{32'h1b0, 32'h16e, 32'h167, 32'h130};
  int          tl [4] = '{4950, 2634, 5034, 2700};
  led_matrix_scan_current_gain dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .line_on_o(line_on_o), .sink_on_o(sink_on_o), .line_clamp_o(line_clamp_o),
    .sink_precharge_o(sink_precharge_o), .sink_comp_o(sink_comp_o), .subperiod_start_o(subperiod_start_o));
  led_matrix_model model_u (.clk_i(clk_i), .clr_i(mclr), .line_on_i(line_on_o), .top_line_o(top_line),
    .clash_o(clash));
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One classic cycle; the 50-edge bound keeps a dead slave from hanging the task
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1)
      error_cnt++;
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rd, e);
  endtask
  task automatic wait_sub(output int c);
    c = 0;
    do
    begin
      @(posedge clk_i);
      c++;
    end
    while (subperiod_start_o !== 1'b1 && c < 9000);
    if (subperiod_start_o !== 1'b1)
      error_cnt++;
  endtask
  task automatic wait_blank;
    n = 0;
    do
      @(posedge clk_i);
    while (sink_precharge_o === 3'h0 && n++ < 6000);
    if (sink_precharge_o === 3'h0)
      error_cnt++;
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #1900000;
    error_cnt++;
    summarize();
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++)
      rc(ra[i], rv[i]);
    chk("lines idle", 32'(line_on_o), 32'h0);
    $display("test reset done");
    wb(1'b1, 8'h10, 32'h7f7f7f);
    wb(1'b1, 8'h1c, 32'hff);
    for (int k = 0; k < 7; k++)
    begin
      wb(1'b1, 8'h0c, 32'(k));
      rc(8'h24, pk[k]);
    end
    wb(1'b1, 8'h0c, 32'h7);
    rc(8'h0c, 32'h6);
    $display("test peak done");
    wb(1'b1, 8'h10, 32'h7f4001);
    for (int i = 3; i < 6; i++)
    begin
      wb(1'b1, 8'h18, 32'(i));
      wb(1'b1, 8'h1c, i == 3 ? 32'hff : 32'h33);
      rc(8'h24, i == 3 ? 32'h313 : i == 4 ? 32'h275e : 32'h4e20);
    end
    wb(1'b1, 8'h18, 32'h12);
    rc(8'h18, 32'h5);
    wb(1'b1, 8'h04, 32'h1d1);
    repeat (2) @(posedge clk_i);
    chk("comp", {sink_comp_o[0], sink_comp_o[4], sink_comp_o[17]}, 32'h057);
    $display("test gains done");
    wb(1'b1, 8'h14, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, 8'h00, tc[i]);
      wait_sub(len);
      wait_sub(len);
      mclr <= 1'b0;
      wait_sub(len);
      chk("sub-period", 32'(len), 32'(tl[i]));
      chk("top line", {top_line, 3'(clash)}, i == 0 ? 32'h50 : 32'h28);
      n = 0;
      do
        @(posedge clk_i);
      while (line_on_o === 11'h0 && n++ < 1000);
      chk("sink at line start", 32'(sink_on_o), i == 1 ? 32'h0 : 32'h3ffff);
      @(posedge clk_i);
      chk("sink after delay", 32'(sink_on_o), 32'h3ffff);
      mclr <= 1'b1;
    end
    rc(8'h28, 32'hd05);
    $display("test timing done");
    wb(1'b1, 8'h08, 32'hd);
    wb(1'b1, 8'h0c, 32'h5);
    wb(1'b0, 8'h20, 32'h0);
    chk("instant peak", rd & 32'h700, 32'h500);
    wait_blank();
    chk("deghost", {line_clamp_o, sink_precharge_o}, 32'hd);
    wb(1'b1, 8'h00, 32'h2b0);
    wb(1'b1, 8'h14, 32'h0);
    wb(1'b1, 8'h0c, 32'h1);
    wb(1'b1, 8'h08, 32'h2);
    wb(1'b0, 8'h20, 32'h0);
    chk("held peak", rd & 32'h700, 32'h500);
    wb(1'b1, 8'h14, 32'h1);
    wb(1'b0, 8'h20, 32'h0);
    chk("applied peak", rd & 32'h700, 32'h100);
    wait_blank();
    chk("applied deghost", {line_clamp_o, sink_precharge_o}, 32'h2);
    $display("test refresh done");
    summarize();
  end
endmodule // testbench
